// >>> include/i2cas_pkg.sv
// package: register map, field positions and carriers for the address/ack status slice
// =====================================================================
// Function
// RL1: in slave receive, own or general call address after start sets address flag.
// RL2: addressing format compares first byte with seven own-address bits.
// RL3: address flag clears on write 0 after it was read as 1.
// RL4: both flags clear on data buffer write (transmit) or read (receive).
// RL5: addressing format, slave receive, first byte zero sets general call flag.
// RL6: general call flag clears on write 0 after it was read as 1.
// RL7: transmit mode captures returned acknowledge; 0 acked, 1 not acked.
// RL8: receive mode drives software acknowledge value on data line at ack time.
// RL9: acknowledge read returns captured value if transmit, software value otherwise.
// RL10: both flags and acknowledge bit reset to 0.
// RL11: serial/timer control is eight-bit read/write, resets to zero.
// RL12: bit 7 gives two port pins the bus-driving buffer type.
// RL13: bits 6 and 5 extend channel 1 and 0 rate select.
// RL14: write 0 to flag not read as 1 since set leaves it set.
package i2cas_pkg;
  // =====================================================================
  // register byte addresses
  localparam logic [3:0] I2CAS_ADR_STATUS   = 4'h0;
  localparam logic [3:0] I2CAS_ADR_STCTRL   = 4'h4;
  localparam logic [3:0] I2CAS_ADR_OWNADDR  = 4'h8;
  localparam logic [3:0] I2CAS_ADR_MODE     = 4'hc;
  localparam logic [3:0] I2CAS_ADR_DATABUF  = 4'h0;
  localparam logic [4:0] I2CAS_ADR_DATAHI   = 5'h10;
  localparam logic [4:0] I2CAS_ADR_IRQSTAT  = 5'h14;
  localparam logic [4:0] I2CAS_ADR_IRQEN    = 5'h18;
  localparam logic [4:0] I2CAS_ADR_IRQCLR   = 5'h1c;
  // status fields
  localparam int I2CAS_BIT_ADDRFLAG = 2;
  localparam int I2CAS_BIT_GCFLAG   = 1;
  localparam int I2CAS_BIT_ACK      = 0;
  // serial/timer control fields
  localparam int I2CAS_BIT_XBUF  = 7;
  localparam int I2CAS_BIT_RATE1 = 6;
  localparam int I2CAS_BIT_RATE0 = 5;
  // mode register fields
  localparam int I2CAS_BIT_TRS    = 0;
  localparam int I2CAS_BIT_FS     = 1;
  localparam int I2CAS_BIT_SLAVE  = 2;
  localparam int I2CAS_MODE_RATE  = 3;
  // reset values and general call byte
  localparam logic [7:0] I2CAS_RST_STCTRL  = 8'h00;
  localparam logic [6:0] I2CAS_RST_OWNADDR = 7'h00;
  localparam logic [7:0] I2CAS_GENCALL     = 8'h00;
  // interrupt causes
  localparam int I2CAS_IRQ_ADDR = 0;
  localparam int I2CAS_IRQ_GC   = 1;
  localparam int I2CAS_IRQ_NACK = 2;
  localparam int I2CAS_IRQ_N    = 3;

  typedef struct packed {
    logic       strt;
    logic       firstDone;
    logic [7:0] firstByte;
    logic       ackTime;
    logic       ackSample;
  } i2cas_link_t;

  typedef struct packed {
    logic [2:0] rateSel0;
    logic [2:0] rateSel1;
    logic       rateExt0;
    logic       rateExt1;
  } i2cas_rate_t;
endpackage

// >>> core/i2cas_status.sv
// address recognition, general call and acknowledge status with wishbone register access
`timescale 1ns/1ps
module i2cas_status
  import i2cas_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [ADDR_W-1:0]  adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  // events from the serial engine
  input  wire i2cas_pkg::i2cas_link_t link,
  input  wire logic               rxData,
  // data line drive at acknowledge time
  output logic                    sdaOut,
  output logic                    sdaOe,
  // port pin buffer select and rate choice
  output logic                    extraBufferSelect,
  output i2cas_pkg::i2cas_rate_t  rate,
  // interrupt
  output logic                    irq
);
  import i2cas_pkg::*;

  initial begin
    if (ADDR_W < 5) $error("ADDR_W too small for register map");
  end

  // =====================================================================
  // bus decode
  logic       access;
  logic       wrEn;
  logic       rdEn;
  logic [4:0] adr;
  assign adr    = adr_i[4:0];
  assign access = cyc_i && stb_i && !ack_o;
  assign wrEn   = access && we_i && sel_i[0];
  assign rdEn   = access && !we_i;

  logic wrStatus;
  logic rdStatus;
  logic dataBufAccess;
  assign wrStatus = wrEn && adr == {1'b0, I2CAS_ADR_STATUS};
  assign rdStatus = rdEn && adr == {1'b0, I2CAS_ADR_STATUS};

  // =====================================================================
  // control registers
  logic [7:0] serialTimerControl;
  logic [6:0] ownAddress;
  logic       transmitSelect;
  logic       formatSelect;
  logic       slaveMode;
  logic [5:0] rateSelect;
  logic [I2CAS_IRQ_N-1:0] irqEnable;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serialTimerControl <= I2CAS_RST_STCTRL; // RL11
    end else if (wrEn && adr == {1'b0, I2CAS_ADR_STCTRL}) begin
      serialTimerControl <= dat_i[7:0]; // RL11
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ownAddress <= I2CAS_RST_OWNADDR;
    end else if (wrEn && adr == {1'b0, I2CAS_ADR_OWNADDR}) begin
      ownAddress <= dat_i[7:1];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      transmitSelect <= 1'b0;
      formatSelect   <= 1'b0;
      slaveMode      <= 1'b0;
      rateSelect     <= 6'h00;
    end else if (wrEn && adr == {1'b0, I2CAS_ADR_MODE}) begin
      transmitSelect <= dat_i[I2CAS_BIT_TRS];
      formatSelect   <= dat_i[I2CAS_BIT_FS];
      slaveMode      <= dat_i[I2CAS_BIT_SLAVE];
      rateSelect     <= dat_i[I2CAS_MODE_RATE+5:I2CAS_MODE_RATE];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqEnable <= '0;
    end else if (wrEn && adr == I2CAS_ADR_IRQEN) begin
      irqEnable <= dat_i[I2CAS_IRQ_N-1:0];
    end
  end

  // data buffer accesses in the mode that auto-clears the flags
  assign dataBufAccess = (adr == I2CAS_ADR_DATAHI) &&
                         ((wrEn && transmitSelect) || (rdEn && !transmitSelect)); // RL4

  assign extraBufferSelect = serialTimerControl[I2CAS_BIT_XBUF]; // RL12
  assign rate.rateExt1 = serialTimerControl[I2CAS_BIT_RATE1]; // RL13
  assign rate.rateExt0 = serialTimerControl[I2CAS_BIT_RATE0]; // RL13
  assign rate.rateSel1 = rateSelect[5:3];
  assign rate.rateSel0 = rateSelect[2:0];

  // =====================================================================
  // address recognition
  logic addrMatch;
  logic gcMatch;
  logic recvSlave;
  logic firstArmed;

  // only the byte that closes the first frame after a start is an address;
  // later data bytes that reach the same engine strobe must not match
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      firstArmed <= 1'b0;
    end else if (link.strt) begin
      firstArmed <= 1'b1; // RL1
    end else if (link.firstDone) begin
      firstArmed <= 1'b0;
    end
  end

  assign recvSlave = slaveMode && !transmitSelect && !formatSelect && firstArmed;
  assign gcMatch   = recvSlave && link.firstDone && link.firstByte == I2CAS_GENCALL; // RL5
  assign addrMatch = recvSlave && link.firstDone &&
                     (link.firstByte[7:1] == ownAddress || gcMatch); // RL1 RL2

  logic addrFlag;
  logic gcFlag;
  logic addrSeen;
  logic gcSeen;

  // status-write flag clears need a prior read as 1; a new set always wins over any clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addrFlag <= 1'b0; // RL10
      addrSeen <= 1'b0;
    end else if (addrMatch) begin
      addrFlag <= 1'b1; // RL1
      addrSeen <= 1'b0;
    end else if (dataBufAccess) begin
      addrFlag <= 1'b0; // RL4
      addrSeen <= 1'b0;
    end else if (wrStatus && !dat_i[I2CAS_BIT_ADDRFLAG] && addrSeen) begin
      addrFlag <= 1'b0; // RL3
      addrSeen <= 1'b0;
    end else if (rdStatus && addrFlag) begin
      addrSeen <= 1'b1; // RL14
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gcFlag <= 1'b0; // RL10
      gcSeen <= 1'b0;
    end else if (gcMatch) begin
      gcFlag <= 1'b1; // RL5
      gcSeen <= 1'b0;
    end else if (dataBufAccess) begin
      gcFlag <= 1'b0; // RL4
      gcSeen <= 1'b0;
    end else if (wrStatus && !dat_i[I2CAS_BIT_GCFLAG] && gcSeen) begin
      gcFlag <= 1'b0; // RL6
      gcSeen <= 1'b0;
    end else if (rdStatus && gcFlag) begin
      gcSeen <= 1'b1; // RL14
    end
  end

  // =====================================================================
  // acknowledge bit: software value and captured value kept apart
  logic ackSoft;
  logic ackCaptured;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ackSoft <= 1'b0; // RL10
    end else if (wrStatus) begin
      ackSoft <= dat_i[I2CAS_BIT_ACK];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ackCaptured <= 1'b0; // RL10
    end else if (transmitSelect && link.ackTime) begin
      ackCaptured <= link.ackSample; // RL7
    end
  end

  // open drain: only a 0 is driven, a 1 releases the line
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaOe <= 1'b0;
    end else begin
      sdaOe <= !transmitSelect && link.ackTime && rxData && !ackSoft; // RL8
    end
  end
  assign sdaOut = 1'b0;

  logic ackRead;
  assign ackRead = transmitSelect ? ackCaptured : ackSoft; // RL9

  // =====================================================================
  // interrupts: sticky, set beats clear
  logic [I2CAS_IRQ_N-1:0] irqStatus;
  logic [I2CAS_IRQ_N-1:0] irqSet;
  logic [I2CAS_IRQ_N-1:0] irqClr;
  assign irqSet[I2CAS_IRQ_ADDR] = addrMatch;
  assign irqSet[I2CAS_IRQ_GC]   = gcMatch;
  assign irqSet[I2CAS_IRQ_NACK] = transmitSelect && link.ackTime && link.ackSample;
  assign irqClr = (wrEn && adr == I2CAS_ADR_IRQCLR) ? dat_i[I2CAS_IRQ_N-1:0] : '0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStatus <= '0;
    end else begin
      irqStatus <= irqSet | (irqStatus & ~irqClr);
    end
  end
  assign irq = |(irqStatus & irqEnable);

  // =====================================================================
  // read data and acknowledge, one wait state
  logic [31:0] next_dat;
  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (adr)
      {1'b0, I2CAS_ADR_STATUS}: begin
        next_dat[I2CAS_BIT_ADDRFLAG] = addrFlag;
        next_dat[I2CAS_BIT_GCFLAG]   = gcFlag;
        next_dat[I2CAS_BIT_ACK]      = ackRead;
      end
      {1'b0, I2CAS_ADR_STCTRL}:  next_dat[7:0] = serialTimerControl;
      {1'b0, I2CAS_ADR_OWNADDR}: next_dat[7:1] = ownAddress;
      {1'b0, I2CAS_ADR_MODE}: begin
        next_dat[I2CAS_BIT_TRS]   = transmitSelect;
        next_dat[I2CAS_BIT_FS]    = formatSelect;
        next_dat[I2CAS_BIT_SLAVE] = slaveMode;
        next_dat[I2CAS_MODE_RATE+5:I2CAS_MODE_RATE] = rateSelect;
      end
      I2CAS_ADR_IRQSTAT: next_dat[I2CAS_IRQ_N-1:0] = irqStatus;
      I2CAS_ADR_IRQEN:   next_dat[I2CAS_IRQ_N-1:0] = irqEnable;
      default:           next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= access;
      if (rdEn) begin
        dat_o <= next_dat;
      end
    end
  end
endmodule

// >>> test/i2cas_asserts.sv
// checker: bus answer, interrupt, data line and control outputs of the status slice
`timescale 1ns/1ps
module i2cas_asserts
  import i2cas_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // clock, reset and bus
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   cyc_i,
  input wire logic                   stb_i,
  input wire logic                   we_i,
  input wire logic [ADDR_W-1:0]      adr_i,
  input wire logic [3:0]             sel_i,
  input wire logic [31:0]            dat_i,
  input wire logic [31:0]            dat_o,
  input wire logic                   ack_o,
  // serial side and outputs
  input wire i2cas_pkg::i2cas_link_t link,
  input wire logic                   rxData,
  input wire logic                   sdaOut,
  input wire logic                   sdaOe,
  input wire logic                   extraBufferSelect,
  input wire i2cas_pkg::i2cas_rate_t rate,
  input wire logic                   irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // low byte of each register as written; word index is adr_i[4:2]
  logic       wr;
  logic [7:0] sh [8];
  assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh <= '{default: 8'h00};
    end else if (wr) begin
      sh[adr_i[4:2]] <= dat_i[7:0];
    end
  end
  property p_ackResp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ackResp: assert property (p_ackResp) else $error("bus request left unanswered");
  property p_xbuf; wr && adr_i == 5'h04 |=> extraBufferSelect == $past(dat_i[7]); endproperty
  a_xbuf: assert property (p_xbuf) else $error("buffer select off control bit");
  property p_rateExt; wr && adr_i == 5'h04 |=> {rate.rateExt1, rate.rateExt0} == $past(dat_i[6:5]);
  endproperty
  a_rateExt: assert property (p_rateExt) else $error("rate extend off control bits");
  property p_addrSet; link.firstDone && sh[3][2:0] == 3'b100 && sh[6][0]
    && link.firstByte[7:1] == sh[2][7:1] |-> ##[1:2] irq; endproperty
  a_addrSet: assert property (p_addrSet) else $error("own address not flagged");
  property p_gcSet; link.firstDone && link.firstByte == I2CAS_GENCALL && sh[3][2:0] == 3'b100
    && sh[6][1] |-> ##[1:2] irq; endproperty
  a_gcSet: assert property (p_gcSet) else $error("general call not flagged");
  property p_sdaDrive; link.ackTime && rxData && !sh[3][0] && !sh[0][0] |=> sdaOe; endproperty
  a_sdaDrive: assert property (p_sdaDrive) else $error("ack not driven low");
  property p_sdaQuiet; sdaOe |-> !sdaOut && $past(link.ackTime && rxData && !sh[0][0]);
  endproperty
  a_sdaQuiet: assert property (p_sdaQuiet) else $error("data line pulled outside ack");
  property p_nackIrq; link.ackTime && sh[3][0] && link.ackSample && sh[6][2] |-> ##[1:2] irq;
  endproperty
  a_nackIrq: assert property (p_nackIrq) else $error("returned nack not captured");
endmodule
bind i2cas_status i2cas_asserts #(.ADDR_W(ADDR_W)) chk (.*);

// >>> test/i2cas_peer.sv
// far-side bus party: first byte after start and acknowledge slots
`timescale 1ns/1ps
module i2cas_peer
  import i2cas_pkg::*;
(
  // clock and data line pull
  input  wire logic              clk,
  input  wire logic              sdaOe,
  // bus events
  output i2cas_pkg::i2cas_link_t link,
  output logic                   rxData,
  output logic                   lineLvl
);
  initial begin
    link = '0;
    rxData = 1'b0;
    lineLvl = 1'b1;
  end
  // stale byte and ack levels are inverted so they never pass for fresh ones
  task automatic sendFirst(input logic [7:0] b);
    @(posedge clk);
    link.strt <= 1'b1;
    @(posedge clk);
    link.strt <= 1'b0;
    link.firstDone <= 1'b1;
    link.firstByte <= b;
    @(posedge clk);
    link.firstDone <= 1'b0;
    link.firstByte <= ~b;
  endtask
  task automatic ackSlot(input logic s, input logic rx);
    @(posedge clk);
    rxData <= rx;
    link.ackTime <= 1'b1;
    link.ackSample <= s;
    @(posedge clk);
    link.ackTime <= 1'b0;
    link.ackSample <= ~s;
    @(posedge clk);
    lineLvl <= !sdaOe;
    rxData <= 1'b0;
  endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the address/ack status slice
`timescale 1ns/1ps
module testbench;
  import i2cas_pkg::*;
  logic        clk, rst_b, cyc_i, stb_i, we_i, ack_o, rxData, sdaOut, sdaOe, lineLvl;
  logic        extraBufferSelect, irq;
  logic [4:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o;
  i2cas_link_t link;
  i2cas_rate_t rate;
  int          err_count, tests_run;
  logic [31:0] expQ[$];
  logic [6:0]  own;
  logic [7:0]  v;
  i2cas_status uut (.*);
  i2cas_peer peer (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic irqIs(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // read data is compared when the answer comes, against the oldest note
  always @(posedge clk) begin
    if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o, expQ.pop_front());
  end
  task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk);
    while (ack_o !== 1'b1) @(posedge clk);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    wb(a, 1'b0, 32'h0);
  endtask
  task automatic finish_test;
    @(posedge clk);
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    finish_test();
  end
  initial begin
    {rst_b, cyc_i, stb_i, we_i, adr_i, dat_i, err_count, tests_run} = '0;
    sel_i = 4'h1;
    v = 8'($urandom(25));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(5'h00, 8'h00);
    rd(5'h04, 8'h00);
    rd(5'h03, 8'h00);
    v = 8'($urandom);
    wb(5'h04, 1'b1, {24'h0, v});
    rd(5'h04, v);
    wb(5'h0c, 1'b1, 32'h154);
    @(negedge clk);
    chk({31'h0, extraBufferSelect}, {31'h0, v[7]});
    chk({24'h0, rate}, {24'h0, 3'b010, 3'b101, v[5], v[6]});
    $display("control test done");
    own = {1'b0, 5'($urandom), 1'b1};
    wb(5'h08, 1'b1, {24'h0, own, 1'b0});
    wb(5'h18, 1'b1, 32'h3);
    peer.sendFirst({~own, 1'b1});
    rd(5'h00, 8'h00);
    peer.sendFirst({own, 1'b0});
    irqIs(1'b1);
    wb(5'h00, 1'b1, 32'h0);
    rd(5'h00, 8'h04);
    wb(5'h00, 1'b1, 32'h0);
    rd(5'h00, 8'h00);
    peer.sendFirst(I2CAS_GENCALL);
    rd(5'h00, 8'h06);
    wb(5'h00, 1'b1, 32'h0);
    rd(5'h00, 8'h00);
    peer.sendFirst(I2CAS_GENCALL);
    rd(5'h10, 8'h00);
    rd(5'h00, 8'h00);
    peer.sendFirst(I2CAS_GENCALL);
    wb(5'h0c, 1'b1, 32'h5);
    wb(5'h10, 1'b1, 32'h0);
    rd(5'h00, 8'h00);
    $display("address test done");
    wb(5'h1c, 1'b1, 32'h7);
    peer.ackSlot(1'b1, 1'b0);
    rd(5'h14, 8'h04);
    irqIs(1'b0);
    wb(5'h18, 1'b1, 32'h7);
    irqIs(1'b1);
    wb(5'h1c, 1'b1, 32'h4);
    irqIs(1'b0);
    peer.ackSlot(1'b1, 1'b0);
    wb(5'h00, 1'b1, 32'h0);
    rd(5'h00, 8'h01);
    wb(5'h0c, 1'b1, 32'h4);
    rd(5'h00, 8'h00);
    peer.ackSlot(1'b1, 1'b1);
    @(negedge clk);
    chk({31'h0, lineLvl}, 32'h0);
    wb(5'h00, 1'b1, 32'h1);
    peer.ackSlot(1'b0, 1'b1);
    @(negedge clk);
    chk({31'h0, lineLvl}, 32'h1);
    $display("acknowledge test done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(5'h04, 8'h00);
    rd(5'h00, 8'h00);
    $display("reset test done");
    finish_test();
  end
endmodule
